// file: crp_pkg.sv
/*
  Shared constants and types for the core register and reset block:
  data memory map, reset values, divider and monitor counts, op format.
  Assumes a single 10 MHz clock domain for every user of the package.
*/
package crp_pkg;
  // ---------------------------------------------------------------
  // clocking and widths
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TC_DIV_I = 10;
  localparam logic [3:0] TC_LAST = 4'(TC_DIV_I - 1);
  localparam int DW = 8;
  localparam int PC_W = 15;
  localparam int PCU_W = 7;
  localparam int PCL_W = 8;
  localparam int PROG_BYTES = 4096;
  localparam int RAM_BYTES = 128;
  localparam int RAM_AW = 7;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h00FF;
  localparam logic [7:0] SP_RST = 8'h6F;
  localparam logic [7:0] WD_RST = 8'hC1;
  localparam logic [3:0] D_RST = 4'hF;
  // ---------------------------------------------------------------
  // data memory map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_RAM_TOP = 8'h70;
  localparam logic [7:0] ADR_REG_LO = 8'hF0;
  localparam logic [7:0] ADR_X = 8'hFC;
  localparam logic [7:0] ADR_B = 8'hFD;
  localparam logic [7:0] ADR_SP = 8'hFE;
  localparam logic [7:0] ADR_PSW = 8'hEF;
  localparam logic [7:0] ADR_TIMER_SERIAL_CONTROL_REG = 8'hEE;
  localparam logic [7:0] ADR_INTERRUPT_CONTROL_REG = 8'hE8;
  localparam logic [7:0] ADR_SEG = 8'hE7;
  localparam logic [7:0] ADR_CMPSL = 8'hB7;
  localparam logic [7:0] ADR_WDSVC = 8'hC7;
  localparam logic [7:0] ADR_WAKEUP_EDGE_REG = 8'hC8;
  localparam logic [7:0] ADR_WAKEUP_ENABLE_REG = 8'hC9;
  localparam logic [7:0] ADR_WAKEUP_PENDING_REG = 8'hCA;
  localparam logic [7:0] ADR_LDATA = 8'hD0;
  localparam logic [7:0] ADR_LCFG = 8'hD1;
  localparam logic [7:0] ADR_LPIN = 8'hD2;
  localparam logic [7:0] ADR_GDATA = 8'hD4;
  localparam logic [7:0] ADR_GCFG = 8'hD5;
  localparam logic [7:0] ADR_GPIN = 8'hD6;
  localparam logic [7:0] ADR_DDATA = 8'hDC;
  // ---------------------------------------------------------------
  // field positions and counts
  // ---------------------------------------------------------------
  localparam int PSW_HC = 7;
  localparam int PSW_C = 6;
  localparam int GD_HALT = 7;
  localparam int GC_HALT_CLOCK_DELAY_ENABLE = 7;
  localparam int G_ERR = 1;
  localparam int G_CKO = 7;
  localparam int WD_CM = 0;
  localparam int CM_MIN_TC = 16;
  localparam int CM_MAX_TC = 32;
  localparam int CM_REL_TC = 24;
  localparam int HALT_DLY_TC = 256;
  // ---------------------------------------------------------------
  // op format
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OPC_NOP, OPC_ADD, OPC_SUB, OPC_AND, OPC_OR, OPC_XOR, OPC_SHL,
    OPC_SHR, OPC_LDA, OPC_STA, OPC_LDI, OPC_DECREMENT_SKIP_IF_ZERO, OPC_SETB, OPC_CLRB,
    OPC_TSTB, OPC_TSTA, OPC_JMP, OPC_INTR
  } crp_opc_t;
  typedef enum logic [1:0] {AM_DIRECT, AM_B, AM_X, AM_SP} crp_mode_t;
  typedef enum logic [1:0] {PST_NONE, PST_INC, PST_DEC} crp_post_t;
  typedef struct packed {
    crp_opc_t opc;
    crp_mode_t mode;
    crp_post_t post;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [2:0] bitsel;
  } crp_op_t;
endpackage

// file: crp_ram.sv
/*
  Data RAM for the core: single address, write strobe, registered read.
  Assumes the caller holds the address at least one cycle before use.
*/
`timescale 1ns/1ps
module crp_ram #(
  parameter int AW = 7, // address width
  parameter int DW = 8  // data width
) (
  input wire logic CLK,          // core clock
  input wire logic we,           // write strobe
  input wire logic [AW-1:0] adr, // read and write address
  input wire logic [DW-1:0] wd,  // write data
  output logic [DW-1:0] q        // registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on purpose: contents are undefined at power-up
  always_ff @(posedge CLK) begin
    if (we) begin
      mem[adr] <= wd;
    end
    q <= mem[adr];
  end
endmodule // crp_ram

// file: crp_core.sv
/*
  Core register set with reset initialisation: accumulator, program
  counter, RAM pointers, memory-mapped control and port registers,
  instruction-cycle divider, halt exit and clock monitor error pin.
  Assumes ops come from a sequencer on CLK; pins are asynchronous.
*/
`timescale 1ns/1ps
// Contract
// - one 8-bit add, subtract, logic or shift per instruction cycle.
// - 15-bit program counter, 7-bit upper, 8-bit lower; 8-bit accumulator.
// - both RAM pointers may post-increment or post-decrement per access.
// - stack pointer loads 6F hex on every reset.
// - all registers except accumulator and counter sit in data memory.
// - 4096-byte program space; interrupts jump to address 0FF hex.
// - 128 RAM bytes; F0-FF act as load and decrement-skip registers.
// - alternate, primary and stack pointers live at FC to FE hex.
// - data access is direct or through either pointer or stack pointer.
// - any memory bit settable, clearable, testable; accumulator bits testable.
// - RAM contents undefined after power-up.
// - low reset input initialises; source holds it low until supply stable.
// - reset clears port data and config, pins float; output port high.
// - reset clears counter, status, control, compare select, segment.
// - reset clears wakeup enable and edge; pending stays unknown.
// - monitors held off in reset, armed after; window bits set.
// - slow clock at reset end drives error low; release 16-32 cycles.
// - instruction cycle is the input clock divided by ten.
// - RC option makes clock-out pin an input and halt restart.
// - config zero, data zero gives a floating input pin.
// - with the RC option, second port config bit 7 adds start-up delay after halt.
module crp_core import crp_pkg::*; #(
  parameter int HALT_DLY = HALT_DLY_TC, // halt exit delay in cycles
  parameter bit RC_OSC = 1'b0           // single-pin RC clock option
) (
  input wire logic CLK,          // 10 MHz core clock
  input wire logic RST,          // synchronous reset, high
  input wire logic RESET_N,      // external reset pin, low
  input wire logic CLK_MIN_OK,   // clock above minimum, from detector
  input wire logic [7:0] G_PIN,  // port G pin levels
  input wire logic [7:0] L_PIN,  // port L pin levels
  input wire logic OP_VALID,     // op presented
  input wire crp_op_t OP,        // op, held until taken
  output logic TC,               // instruction-cycle pulse
  output logic OP_TAKEN,         // op executed, one cycle
  output logic [7:0] ACC,        // accumulator
  output logic [14:0] PC,        // program counter
  output logic SKIP,             // last op asks for a skip
  output logic TEST_BIT,         // last tested bit value
  output logic HALTED,           // core halted or waking
  output logic [7:0] L_OUT,      // port L drive value
  output logic [7:0] L_OE,       // port L output enables
  output logic [7:0] G_OUT,      // port G drive value
  output logic [7:0] G_OE,       // port G output enables
  output logic [3:0] D_OUT       // port D output
);
  // ---------------------------------------------------------------
  // pin synchronisers and reset
  // ---------------------------------------------------------------
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic rstn_s;
  logic ok_s;
  logic [7:0] g_s;
  logic [7:0] l_s;
  logic rst_core;

  // first stage feeds only the second stage
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1 <= 18'h00000;
      sync2 <= 18'h00000;
    end else begin
      sync1 <= {RESET_N, CLK_MIN_OK, G_PIN, L_PIN};
      sync2 <= sync1;
    end
  end
  assign {rstn_s, ok_s, g_s, l_s} = sync2;
  // every register below except the RAM, the wakeup pending byte and the L and G7 edge delays sees one synchronised reset edge
  assign rst_core = RST | ~rstn_s;

  // ---------------------------------------------------------------
  // instruction-cycle divider
  // ---------------------------------------------------------------
  logic [3:0] phase;
  logic tc_en;

  // one enable in ten clocks instead of a derived clock
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      phase <= 4'h0;
    end else if (phase == TC_LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end
  assign tc_en = (phase == TC_LAST);

  // ---------------------------------------------------------------
  // registers and effective address
  // ---------------------------------------------------------------
  typedef enum {HS_RUN, HS_HALT, HS_DLY} crp_hstate_t;
  crp_hstate_t hstate;
  logic [7:0] ptr_b, ptr_x, ptr_sp;
  logic [7:0] processor_status_word, timer_serial_control_reg, interrupt_control_reg, seg, cmpsl, wdsvc;
  logic [7:0] wakeup_enable_reg, wakeup_edge_reg, wakeup_pending_reg;
  logic [7:0] gdata, gcfg;
  logic [7:0] ea, rd_val, ram_q, wr_val, next_acc, mask;
  logic [6:0] ram_idx;
  logic ram_hit, take, wr_en, uses_mem, c_upd, next_c, next_hc;
  logic next_skip, next_tbit, err;
  logic [8:0] sum, dif;
  logic [4:0] hsum, hdif;
  logic [7:0] l_d;
  logic g7_d;

  assign take = tc_en & OP_VALID & (hstate == HS_RUN);

  // pointer-based or direct addressing
  always_comb begin
    unique case (OP.mode)
      AM_DIRECT: ea = OP.addr;
      AM_B: ea = ptr_b;
      AM_X: ea = ptr_x;
      AM_SP: ea = ptr_sp;
    endcase
  end

  // RAM below 70 plus thirteen of the sixteen register bytes; pointers are flops
  assign ram_hit = (ea < ADR_RAM_TOP) | ((ea >= ADR_REG_LO)
                   & (ea != ADR_X) & (ea != ADR_B) & (ea != ADR_SP));
  assign ram_idx = ea[7] ? {3'b111, ea[3:0]} : ea[6:0];

  crp_ram #(.AW(RAM_AW), .DW(DW)) u_ram (
    .CLK(CLK),
    .we(take & wr_en & ram_hit),
    .adr(ram_idx),
    .wd(wr_val),
    .q(ram_q)
  );

  // data memory read view; halt and idle bits read back as zero
  always_comb begin
    unique case (ea)
      ADR_X: rd_val = ptr_x;
      ADR_B: rd_val = ptr_b;
      ADR_SP: rd_val = ptr_sp;
      ADR_PSW: rd_val = processor_status_word;
      ADR_TIMER_SERIAL_CONTROL_REG: rd_val = timer_serial_control_reg;
      ADR_INTERRUPT_CONTROL_REG: rd_val = interrupt_control_reg;
      ADR_SEG: rd_val = seg;
      ADR_CMPSL: rd_val = cmpsl;
      ADR_WDSVC: rd_val = wdsvc;
      ADR_WAKEUP_EDGE_REG: rd_val = wakeup_edge_reg;
      ADR_WAKEUP_ENABLE_REG: rd_val = wakeup_enable_reg;
      ADR_WAKEUP_PENDING_REG: rd_val = wakeup_pending_reg;
      ADR_LDATA: rd_val = L_OUT;
      ADR_LCFG: rd_val = L_OE;
      ADR_LPIN: rd_val = l_s;
      ADR_GDATA: rd_val = {2'b00, gdata[5:0]};
      ADR_GCFG: rd_val = gcfg;
      ADR_GPIN: rd_val = g_s;
      ADR_DDATA: rd_val = {4'h0, D_OUT};
      default: rd_val = ram_hit ? ram_q : 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  assign mask = 8'h01 << OP.bitsel;
  assign sum = {1'b0, ACC} + {1'b0, rd_val};
  assign dif = {1'b0, ACC} - {1'b0, rd_val};
  assign hsum = {1'b0, ACC[3:0]} + {1'b0, rd_val[3:0]};
  assign hdif = {1'b0, ACC[3:0]} - {1'b0, rd_val[3:0]};

  // one result per op; shifts rotate through carry
  always_comb begin
    next_acc = ACC;
    wr_en = 1'b0;
    wr_val = rd_val;
    uses_mem = 1'b1;
    c_upd = 1'b0;
    next_c = processor_status_word[PSW_C];
    next_hc = processor_status_word[PSW_HC];
    next_skip = 1'b0;
    next_tbit = TEST_BIT;
    unique case (OP.opc)
      OPC_NOP: uses_mem = 1'b0;
      OPC_ADD: begin
        next_acc = sum[7:0];
        c_upd = 1'b1;
        next_c = sum[8];
        next_hc = hsum[4];
      end
      OPC_SUB: begin
        next_acc = dif[7:0];
        c_upd = 1'b1;
        next_c = ~dif[8];
        next_hc = ~hdif[4];
      end
      OPC_AND: next_acc = ACC & rd_val;
      OPC_OR: next_acc = ACC | rd_val;
      OPC_XOR: next_acc = ACC ^ rd_val;
      OPC_SHL: begin
        uses_mem = 1'b0;
        next_acc = {ACC[6:0], processor_status_word[PSW_C]};
        c_upd = 1'b1;
        next_c = ACC[7];
      end
      OPC_SHR: begin
        uses_mem = 1'b0;
        next_acc = {processor_status_word[PSW_C], ACC[7:1]};
        c_upd = 1'b1;
        next_c = ACC[0];
      end
      OPC_LDA: next_acc = rd_val;
      OPC_STA: begin
        wr_en = 1'b1;
        wr_val = ACC;
      end
      OPC_LDI: begin
        wr_en = 1'b1;
        wr_val = OP.imm;
      end
      OPC_DECREMENT_SKIP_IF_ZERO: begin
        wr_en = 1'b1;
        wr_val = rd_val - 8'h01;
        next_skip = (rd_val == 8'h01);
      end
      OPC_SETB: begin
        wr_en = 1'b1;
        wr_val = rd_val | mask;
      end
      OPC_CLRB: begin
        wr_en = 1'b1;
        wr_val = rd_val & ~mask;
      end
      OPC_TSTB: begin
        next_tbit = |(rd_val & mask);
        next_skip = ~next_tbit;
      end
      OPC_TSTA: begin
        uses_mem = 1'b0;
        next_tbit = |(ACC & mask);
        next_skip = ~next_tbit;
      end
      OPC_JMP: uses_mem = 1'b0;
      OPC_INTR: uses_mem = 1'b0;
      default: uses_mem = 1'b0; // undefined op codes act as no-op
    endcase
  end

  // accumulator, counter and op result flags
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      ACC <= 8'h00;
      PC <= PC_RST;
      SKIP <= 1'b0;
      TEST_BIT <= 1'b0;
      OP_TAKEN <= 1'b0;
      TC <= 1'b0;
    end else begin
      TC <= tc_en;
      OP_TAKEN <= take;
      if (take) begin
        ACC <= next_acc;
        SKIP <= next_skip;
        TEST_BIT <= next_tbit;
        if (OP.opc == OPC_JMP) begin
          PC <= {OP.imm[PCU_W-1:0], OP.addr};
        end else if (OP.opc == OPC_INTR) begin
          PC <= INT_VECTOR;
        end else begin
          PC <= PC + (next_skip ? 15'h0002 : 15'h0001);
        end
      end
    end
  end

  // pointers; a memory write to a pointer beats its own post step
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      ptr_b <= 8'h00;
      ptr_x <= 8'h00;
      ptr_sp <= SP_RST;
    end else if (take) begin
      if (wr_en && ea == ADR_B) begin
        ptr_b <= wr_val;
      end else if (uses_mem && OP.mode == AM_B) begin
        if (OP.post == PST_INC) ptr_b <= ptr_b + 8'h01;
        if (OP.post == PST_DEC) ptr_b <= ptr_b - 8'h01;
      end
      if (wr_en && ea == ADR_X) begin
        ptr_x <= wr_val;
      end else if (uses_mem && OP.mode == AM_X) begin
        if (OP.post == PST_INC) ptr_x <= ptr_x + 8'h01;
        if (OP.post == PST_DEC) ptr_x <= ptr_x - 8'h01;
      end
      if (wr_en && ea == ADR_SP) ptr_sp <= wr_val;
    end
  end

  // ---------------------------------------------------------------
  // memory-mapped control and port registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      processor_status_word <= 8'h00;
      timer_serial_control_reg <= 8'h00;
      interrupt_control_reg <= 8'h00;
      seg <= 8'h00;
      cmpsl <= 8'h00;
      wakeup_enable_reg <= 8'h00;
      wakeup_edge_reg <= 8'h00;
      wdsvc <= WD_RST;
      L_OUT <= 8'h00;
      L_OE <= 8'h00;
      gdata <= 8'h00;
      gcfg <= 8'h00;
      D_OUT <= D_RST;
    end else if (take) begin
      if (c_upd) processor_status_word[PSW_HC:PSW_C] <= {next_hc, next_c};
      if (wr_en) begin
        unique case (ea)
          ADR_PSW: processor_status_word <= wr_val;
          ADR_TIMER_SERIAL_CONTROL_REG: timer_serial_control_reg <= wr_val;
          ADR_INTERRUPT_CONTROL_REG: interrupt_control_reg <= wr_val;
          ADR_SEG: seg <= wr_val;
          ADR_CMPSL: cmpsl <= wr_val;
          ADR_WAKEUP_ENABLE_REG: wakeup_enable_reg <= wr_val;
          ADR_WAKEUP_EDGE_REG: wakeup_edge_reg <= wr_val;
          ADR_WDSVC: wdsvc <= wr_val;
          ADR_LDATA: L_OUT <= wr_val;
          ADR_LCFG: L_OE <= wr_val;
          ADR_GDATA: gdata <= wr_val;
          ADR_GCFG: gcfg <= wr_val;
          ADR_DDATA: D_OUT <= wr_val[3:0];
          default: ;
        endcase
      end
    end
  end

  logic [7:0] wk_set;
  // per-bit edge select: falling when the edge bit is one, else rising
  assign wk_set = (wakeup_edge_reg & l_d & ~l_s) | (~wakeup_edge_reg & l_s & ~l_d);

  // pending edges are not reset; a new edge wins over a software write
  always_ff @(posedge CLK) begin
    l_d <= l_s;
    g7_d <= g_s[G_CKO];
    if (take && wr_en && ea == ADR_WAKEUP_PENDING_REG) begin
      wakeup_pending_reg <= wr_val | wk_set;
    end else begin
      wakeup_pending_reg <= wakeup_pending_reg | wk_set;
    end
  end

  // port G drive: error pin owned by monitor, G6 and G7 never driven
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      G_OUT <= 8'h00;
      G_OE <= 8'h00;
    end else begin
      G_OUT <= {2'b00, gdata[5:2], 1'b0, gdata[0]};
      G_OE <= {2'b00, gcfg[5:2], err, gcfg[0]};
    end
  end

  // ---------------------------------------------------------------
  // halt and restart
  // ---------------------------------------------------------------
  logic [15:0] dly_cnt;
  logic wake;

  // restart from G7 rise only with the RC option, or enabled wakeups
  assign wake = (RC_OSC & g_s[G_CKO] & ~g7_d) | (|(wakeup_enable_reg & wakeup_pending_reg));

  always_ff @(posedge CLK) begin
    if (rst_core) begin
      hstate <= HS_RUN;
      dly_cnt <= 16'h0000;
      HALTED <= 1'b0;
    end else begin
      HALTED <= (hstate != HS_RUN);
      unique case (hstate)
        HS_RUN: begin
          if (take && wr_en && ea == ADR_GDATA && wr_val[GD_HALT]) begin
            hstate <= HS_HALT;
          end
        end
        HS_HALT: begin
          dly_cnt <= 16'h0000;
          if (wake) begin
            hstate <= (RC_OSC && gcfg[GC_HALT_CLOCK_DELAY_ENABLE]) ? HS_DLY : HS_RUN;
          end
        end
        HS_DLY: begin
          if (tc_en) begin
            dly_cnt <= dly_cnt + 16'h0001;
            if (dly_cnt == 16'(HALT_DLY - 1)) hstate <= HS_RUN;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock monitor
  // ---------------------------------------------------------------
  logic [5:0] cm_cnt;

  // inhibited in reset; armed by the monitor bit once reset ends
  always_ff @(posedge CLK) begin
    if (rst_core) begin
      err <= 1'b0;
      cm_cnt <= 6'h00;
    end else if (!ok_s) begin
      cm_cnt <= 6'h00;
      if (wdsvc[WD_CM]) err <= 1'b1;
    end else if (err && tc_en) begin
      cm_cnt <= cm_cnt + 6'h01;
      if (cm_cnt == 6'(CM_REL_TC - 1)) begin
        err <= 1'b0;
        cm_cnt <= 6'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  localparam int CM_LO = CM_MIN_TC * TC_DIV_I;
  localparam int CM_HI = CM_MAX_TC * TC_DIV_I;
  int ok_run;

  // clocks of good frequency seen while the error is showing
  always_ff @(posedge CLK) begin
    if (rst_core || !err || !ok_s) ok_run <= 0;
    else ok_run <= ok_run + 1;
  end

  sequence s_tc_gap;
    (!TC) [*8] ##1 !TC ##1 TC;
  endsequence
  sequence s_reset_end;
    $fell(rst_core);
  endsequence

  property p_tc_period;
    @(posedge CLK) disable iff (rst_core) TC |-> ##1 s_tc_gap;
  endproperty
  a_tc_period: assert property (p_tc_period)
    else $error("instruction pulse not every ten clocks");

  property p_sp_reset;
    @(posedge CLK) disable iff (RST) s_reset_end |-> ptr_sp == SP_RST;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("stack pointer not 6F after reset");

  property p_ctl_reset;
    @(posedge CLK) disable iff (RST) s_reset_end |-> PC == PC_RST
      && processor_status_word == 8'h00 && timer_serial_control_reg == 8'h00 && interrupt_control_reg == 8'h00
      && cmpsl == 8'h00 && seg == 8'h00;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("control registers not cleared by reset");

  property p_port_reset;
    @(posedge CLK) disable iff (RST) s_reset_end |-> L_OE == 8'h00
      && L_OUT == 8'h00 && G_OE == 8'h00 && D_OUT == D_RST;
  endproperty
  a_port_reset: assert property (p_port_reset)
    else $error("ports not floating or output port not high");

  property p_wake_reset;
    @(posedge CLK) disable iff (RST) s_reset_end |->
      wakeup_enable_reg == 8'h00 && wakeup_edge_reg == 8'h00 && wdsvc == WD_RST && !err;
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("wakeup or monitor state wrong after reset");

  property p_intr_vec;
    @(posedge CLK) disable iff (rst_core)
      take && OP.opc == OPC_INTR |=> PC == INT_VECTOR && OP_TAKEN;
  endproperty
  a_intr_vec: assert property (p_intr_vec)
    else $error("interrupt did not vector to 0FF");

  property p_add;
    @(posedge CLK) disable iff (rst_core) take && OP.opc == OPC_ADD
      |=> {processor_status_word[PSW_C], ACC} == {1'b0, $past(ACC)} + {1'b0, $past(rd_val)};
  endproperty
  a_add: assert property (p_add)
    else $error("add result or carry wrong");

  property p_post_inc;
    @(posedge CLK) disable iff (rst_core) take && uses_mem
      && OP.mode == AM_B && OP.post == PST_INC && !(wr_en && ea == ADR_B)
      |=> ptr_b == $past(ptr_b) + 8'h01;
  endproperty
  a_post_inc: assert property (p_post_inc)
    else $error("primary pointer did not post-increment");

  property p_cm_set;
    @(posedge CLK) disable iff (rst_core)
      !ok_s && wdsvc[WD_CM] |=> err ##1 !G_OUT[G_ERR] && G_OE[G_ERR];
  endproperty
  a_cm_set: assert property (p_cm_set)
    else $error("slow clock did not drive the error pin low");

  property p_cm_release;
    @(posedge CLK) disable iff (rst_core)
      $fell(err) |-> $past(ok_run) >= CM_LO && $past(ok_run) <= CM_HI;
  endproperty
  a_cm_release: assert property (p_cm_release)
    else $error("error pin released outside 16 to 32 cycles");
endmodule // crp_core

// file: crp_rst_src.sv
/*
  Far-side model: external reset source and clock-rate detector.
  Assumes a free-running CLK; the bench raises slow to starve clock.
*/
`timescale 1ns/1ps
module crp_rst_src #(
  parameter int HOLD = 8 // clocks the pin stays low at start
) (
  input wire logic CLK,   // core clock
  input wire logic slow,  // bench asks for a slow clock
  output logic RESET_N,   // reset pin, low while supply ramps
  output logic CLK_MIN_OK // detector output, high when fast enough
);
  int n = 0;
  initial begin
    RESET_N = 1'b0;
    CLK_MIN_OK = 1'b1;
  end
  // pin released only once supply has settled
  always @(posedge CLK) begin
    if (n < HOLD) n <= n + 1;
    RESET_N <= (n >= HOLD);
    CLK_MIN_OK <= ~slow;
  end
endmodule // crp_rst_src

// file: crp_core_tb.sv
/*
  Testbench for crp_core: reset values, op sequences, clock monitor.
  Assumes crp_pkg and crp_rst_src are compiled first.
*/
`timescale 1ns/1ps
module crp_core_tb import crp_pkg::*;;
  logic CLK, RST, RESET_N, CLK_MIN_OK, OP_VALID, slow;
  logic TC, OP_TAKEN, SKIP, HALTED, TEST_BIT;
  logic [7:0] ACC, G_OUT, G_OE, L_OE, L_OUT, lpin;
  logic [2:0] bsel;
  logic [14:0] PC;
  logic [3:0] D_OUT;
  crp_op_t OP;
  int miscompares = 0, n_tests = 0, cyc = 0, k;
  crp_rst_src src (.CLK, .slow, .RESET_N, .CLK_MIN_OK);
  crp_core #(.HALT_DLY(4)) dut (.CLK, .RST, .RESET_N, .CLK_MIN_OK,
    .G_PIN(8'h00), .L_PIN(lpin), .OP_VALID, .OP, .TC, .OP_TAKEN,
    .ACC, .PC, .SKIP, .TEST_BIT, .HALTED, .L_OUT, .L_OE,
    .G_OUT, .G_OE, .D_OUT);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task conclude;
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // valid is held across ops so no edge sees it dropped and re-raised
  task op(crp_opc_t o, crp_mode_t m, crp_post_t p, logic [7:0] a, i);
    OP <= '{o, m, p, a, i, bsel};
    OP_VALID <= 1'b1;
    for (k = 0; k < 30; k++) begin
      @(posedge CLK);
      if (OP_TAKEN === 1'b1) break;
    end
    chk(k < 30, 1);
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // hang guard, run needs well under a thousand clocks
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    RST = 1'b1;
    OP_VALID = 1'b0;
    OP = '0;
    slow = 1'b0;
    lpin = 8'h00;
    bsel = 3'h0;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    repeat (16) @(posedge CLK);
    chk(D_OUT, 4'hF);
    chk({L_OE, G_OE}, 16'h0000);
    chk(L_OUT, 8'h00);
    chk(PC, 15'h0000);
    for (k = 0; k < 20 && TC !== 1'b1; k++) @(posedge CLK);
    @(posedge CLK);
    k = 1;
    while (TC !== 1'b1 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    chk(k, 10);
    // starve the clock: error pin driven low, then released late
    slow <= 1'b1;
    repeat (10) @(posedge CLK);
    chk({G_OE[1], G_OUT[1]}, 2'b10);
    slow <= 1'b0;
    repeat (150) @(posedge CLK);
    chk(G_OE[1], 1'b1);
    repeat (200) @(posedge CLK);
    chk(G_OE[1], 1'b0);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hF0, 8'h05);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hF0, 8'h00);
    chk(ACC, 8'h05);
    op(OPC_ADD, AM_DIRECT, PST_NONE, 8'hF0, 8'h00);
    chk(ACC, 8'h0A);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hFE, 8'h00);
    chk(ACC, 8'h6F);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hFD, 8'h10);
    op(OPC_STA, AM_B, PST_INC, 8'h00, 8'h00);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hFD, 8'h00);
    chk(ACC, 8'h11);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'h10, 8'h00);
    chk(ACC, 8'h6F);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hF1, 8'h01);
    op(OPC_DECREMENT_SKIP_IF_ZERO, AM_DIRECT, PST_NONE, 8'hF1, 8'h00);
    chk(SKIP, 1'b1);
    chk(PC, 15'h000B);
    op(OPC_INTR, AM_DIRECT, PST_NONE, 8'h00, 8'h00);
    chk(PC, 15'h00FF);
    op(OPC_JMP, AM_DIRECT, PST_NONE, 8'h34, 8'h12);
    chk(PC, 15'h1234);
    // bit set, clear and test on a register byte, and a bit test on the accumulator
    bsel = 3'h3;
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hF2, 8'h00);
    op(OPC_SETB, AM_DIRECT, PST_NONE, 8'hF2, 8'h00);
    op(OPC_TSTB, AM_DIRECT, PST_NONE, 8'hF2, 8'h00);
    chk({TEST_BIT, SKIP}, 2'b10);
    op(OPC_CLRB, AM_DIRECT, PST_NONE, 8'hF2, 8'h00);
    op(OPC_TSTB, AM_DIRECT, PST_NONE, 8'hF2, 8'h00);
    chk({TEST_BIT, SKIP}, 2'b01);
    op(OPC_TSTA, AM_DIRECT, PST_NONE, 8'h00, 8'h00);
    chk({TEST_BIT, SKIP}, 2'b10);
    bsel = 3'h0;
    // alternate pointer post-decrement, then subtract with carry
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hFC, 8'h12);
    op(OPC_STA, AM_X, PST_DEC, 8'h00, 8'h00);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hFC, 8'h00);
    chk(ACC, 8'h11);
    op(OPC_SUB, AM_DIRECT, PST_NONE, 8'hF0, 8'h00);
    chk(ACC, 8'h0C);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hEF, 8'h00);
    chk(ACC, 8'h40);
    // halt, then wake on a rising edge of L0; valid dropped so the
    // halting op is not taken again after the wake
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hCA, 8'h00);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hC9, 8'h01);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hD4, 8'h80);
    OP_VALID <= 1'b0;
    repeat (20) @(posedge CLK);
    chk(HALTED, 1'b1);
    lpin <= 8'h01;
    repeat (8) @(posedge CLK);
    chk(HALTED, 1'b0);
    op(OPC_LDI, AM_DIRECT, PST_NONE, 8'hFE, 8'h40);
    // second reset in mid-run must restore the presets
    RST <= 1'b1;
    OP_VALID <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(PC, 15'h0000);
    chk(D_OUT, 4'hF);
    RST <= 1'b0;
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hFE, 8'h00);
    chk(ACC, 8'h6F);
    op(OPC_LDA, AM_DIRECT, PST_NONE, 8'hC7, 8'h00);
    chk(ACC, 8'hC1);
    conclude();
  end
endmodule // crp_core_tb
